/* File: dual_position_sequencer.sv */
// Two-speed referencing sequencer with APB register access
//
// Notes on behaviour
// - First move: command velocities, RAM acceleration
// - Second move: relative, command minimum speed, no ramp
// - At end: location zeroed, target cleared or parked
// - Park move follows sequence when park enabled
// - Referenced flag set when sequence ends
// - Only shutdown or hard stop interrupt sequence
// - Sequence start loads target with park or zero
// - Move, sleep, parameter, park commands buffered; the code drops them in st_uv_hold
// - Reads and bus frames served during sequence
// - Command velocities apply only to sequence
// - Zero, dual, soft stop discarded during sequence
// - Drive parameters mid-sequence: all except velocities; the code drops all of them in st_uv_hold
// - Middle level hard stops, upper level soft stops
// - Recovery resumes with RAM velocities and acceleration
// - Absolute move takes shortest way round circle
// - Park code 0x400 means park disabled
// - Sequence waits until supply and step-loss flags clear
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "dual_pos_defs.svh"
module dual_position_sequencer
    import dual_pos_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mv_done,
    input wire logic step_pulse,
    input wire logic step_down,
    input wire logic uv_mid,
    input wire logic uv_upper,
    input wire logic uv_recovered,
    input wire logic steploss_in,
    output logic mv_start,
    output logic [15:0] mv_target,
    output logic [3:0] mv_vmin,
    output logic [3:0] mv_vmax,
    output logic [2:0] mv_accel,
    output logic mv_ramp,
    output logic mv_dir,
    output logic mv_hard_stop,
    output logic mv_soft_stop,
    output logic sleep_req,
    output logic referenced
);

function automatic logic [15:0] add16(input logic [15:0] a,
    input logic [15:0] b);
    add16 = a + b;
endfunction : add16

// Positive when the wrapped difference is non-negative
function automatic logic way_up(input logic [15:0] tgt,
    input logic [15:0] act);
    logic [15:0] d;
    d = tgt - act;
    way_up = ~d[15];
endfunction : way_up

////////////////////////////////////////////////////////////////////////
logic [31:0] prdata_r, prdata_nxt;
logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
logic [31:0] arg_r, arg_nxt;
logic [10:0] vel_r, vel_nxt, park_r, park_nxt;
logic acc, cmd_go;
logic [3:0] cmd_code;

assign acc = psel & penable & pready_r;
assign cmd_go = acc & pwrite & (paddr == `OFF_CMD);
assign cmd_code = pwdata[3:0];

seq_state_t state_r, state_nxt, resume_r, resume_nxt;
logic [15:0] act_r, act_nxt, tgt_r, tgt_nxt;
logic [15:0] t1_r, t1_nxt, off_r, off_nxt;
logic [3:0] svmin_r, svmin_nxt, svmax_r, svmax_nxt;
logic [10:0] ram_r, ram_nxt;
logic uv2_r, uv2_nxt, sl_r, sl_nxt, ref_r, ref_nxt;
logic dwait_r, dwait_nxt, bufv_r, bufv_nxt;
logic [3:0] bufc_r, bufc_nxt;
logic [15:0] bufa_r, bufa_nxt;
logic [10:0] bufv11_r, bufv11_nxt;
logic start_r, start_nxt, ramp_r, ramp_nxt, dir_r, dir_nxt;
logic [15:0] mtgt_r, mtgt_nxt;
logic [3:0] mvmin_r, mvmin_nxt, mvmax_r, mvmax_nxt;
logic hard_r, hard_nxt, soft_r, soft_nxt, slp_r, slp_nxt;
logic park_en, in_seq, seq_end, go, go_ramp, ex_v;
logic [15:0] go_tgt, park16;
logic [3:0] go_vmin, go_vmax, ex_c;
logic [15:0] ex_a;
logic [10:0] ex_vel;

assign park_en = (park_r != `PARK_OFF);
assign park16 = {park_r, 5'h00};
assign in_seq = (state_r != st_idle);

////////////////////////////////////////////////////////////////////////
// Read data is sampled in the setup cycle: zero wait states
always_comb
begin
    pready_nxt = psel & ~penable & ~pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    arg_nxt = arg_r;
    vel_nxt = vel_r;
    park_nxt = park_r;
    if (psel & ~penable)
    begin
        case (paddr)
            `OFF_CMD: prdata_nxt = 32'h0000_0000;
            `OFF_ARG: prdata_nxt = arg_r;
            `OFF_VEL: prdata_nxt = {21'h0, vel_r};
            `OFF_PARK: prdata_nxt = {21'h0, park_r};
            `OFF_STAT: prdata_nxt = {24'h0, bufv_r, dwait_r, sl_r, uv2_r,
                ref_r, 3'(state_r)};
            `OFF_POS: prdata_nxt = {tgt_r, act_r};
            `OFF_RAM: prdata_nxt = {21'h0, ram_r};
            default: pslverr_nxt = 1'b1;
        endcase
    end
    if (acc & pwrite)
    begin
        case (paddr)
            `OFF_ARG: arg_nxt = pwdata;
            `OFF_VEL: vel_nxt = pwdata[10:0];
            `OFF_PARK: park_nxt = pwdata[10:0];
            default: arg_nxt = arg_r;
        endcase
    end
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata_r <= 32'h0000_0000;
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        arg_r <= 32'h0000_0000;
        vel_r <= `VEL_RST;
        park_r <= `PARK_RST;
    end
    else
    begin
        prdata_r <= prdata_nxt;
        pready_r <= pready_nxt;
        pslverr_r <= pslverr_nxt;
        arg_r <= arg_nxt;
        vel_r <= vel_nxt;
        park_r <= park_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
always_comb
begin
    state_nxt = state_r;
    resume_nxt = resume_r;
    act_nxt = act_r;
    tgt_nxt = tgt_r;
    t1_nxt = t1_r;
    off_nxt = off_r;
    svmin_nxt = svmin_r;
    svmax_nxt = svmax_r;
    ram_nxt = ram_r;
    ref_nxt = ref_r;
    dwait_nxt = dwait_r;
    bufv_nxt = bufv_r;
    bufc_nxt = bufc_r;
    bufa_nxt = bufa_r;
    bufv11_nxt = bufv11_r;
    hard_nxt = 1'b0;
    soft_nxt = 1'b0;
    slp_nxt = 1'b0;
    go = 1'b0;
    go_ramp = 1'b1;
    go_tgt = mtgt_r;
    go_vmin = ram_r[3:0];
    go_vmax = ram_r[7:4];
    seq_end = 1'b0;
    ex_v = 1'b0;
    ex_c = cmd_code;
    ex_a = arg_r[15:0];
    ex_vel = vel_r;
    if (step_pulse)
        act_nxt = step_down ? act_r - 16'h0001 : act_r + 16'h0001;
    // Set wins over the clear from a full status read
    uv2_nxt = uv_mid | (uv2_r & ~(cmd_go & cmd_code == `CMD_RD_ALL));
    sl_nxt = steploss_in | (sl_r & ~(cmd_go & cmd_code == `CMD_RD_ALL));
    case (state_r)
        st_idle:
        begin
            if (dwait_r & ~uv2_r & ~sl_r)
            begin
                dwait_nxt = 1'b0;
                tgt_nxt = park_en ? park16 : 16'h0000;
                go = 1'b1;
                go_tgt = t1_r;
                go_vmin = svmin_r;
                go_vmax = svmax_r;
                state_nxt = st_phase1;
            end
            else if (cmd_go)
                ex_v = 1'b1;
        end
        st_phase1, st_phase2, st_park:
        begin
            if (cmd_go)
            begin
                case (cmd_code)
                    `CMD_ABS, `CMD_PARAM, `CMD_PARK, `CMD_SLEEP:
                    begin
                        bufv_nxt = 1'b1;
                        bufc_nxt = cmd_code;
                        bufa_nxt = arg_r[15:0];
                        bufv11_nxt = vel_r;
                    end
                    // Only the acceleration is taken; the command's velocities are dropped
                    `CMD_DRIVE: ram_nxt[10:8] = vel_r[10:8];
                    default: bufv_nxt = bufv_r;
                endcase
            end
            if (mv_done & state_r == st_phase1)
            begin
                go = 1'b1;
                go_ramp = 1'b0;
                go_tgt = add16(t1_r, off_r);
                go_vmin = svmin_r;
                go_vmax = svmin_r;
                state_nxt = st_phase2;
            end
            else if (mv_done & state_r == st_phase2)
            begin
                seq_end = 1'b1;
                act_nxt = 16'h0000;
                tgt_nxt = park_en ? park16 : 16'h0000;
                ref_nxt = 1'b1;
                if (park_en)
                begin
                    go = 1'b1;
                    go_tgt = park16;
                    state_nxt = st_park;
                end
                else
                    state_nxt = st_idle;
            end
            else if (mv_done)
                state_nxt = st_idle;
            if (uv_mid | uv_upper)
            begin
                go = 1'b0;
                hard_nxt = uv_mid;
                soft_nxt = ~uv_mid;
                resume_nxt = state_r;
                state_nxt = st_uv_hold;
            end
        end
        st_uv_hold:
            if (uv_recovered)
            begin
                go = 1'b1;
                state_nxt = resume_r;
            end
        default: state_nxt = st_idle;
    endcase
    // Drain one buffered command once the sequence has fully ended
    if (bufv_r & state_nxt == st_idle & state_r != st_idle)
    begin
        ex_v = 1'b1;
        ex_c = bufc_r;
        ex_a = bufa_r;
        ex_vel = bufv11_r;
        bufv_nxt = 1'b0;
    end
    if (ex_v)
    begin
        case (ex_c)
            `CMD_ABS, `CMD_PARAM:
            begin
                if (ex_c == `CMD_PARAM)
                    ram_nxt[7:0] = ex_vel[7:0];
                tgt_nxt = ex_a;
                go = 1'b1;
                go_tgt = ex_a;
                go_vmin = (ex_c == `CMD_PARAM) ? ex_vel[3:0] : ram_r[3:0];
                go_vmax = (ex_c == `CMD_PARAM) ? ex_vel[7:4] : ram_r[7:4];
            end
            `CMD_PARK:
            begin
                tgt_nxt = park16;
                go = 1'b1;
                go_tgt = park16;
            end
            `CMD_SLEEP:
            begin
                slp_nxt = 1'b1;
                go = park_en;
                go_tgt = park16;
                soft_nxt = ~park_en;
            end
            `CMD_ZERO:
            begin
                act_nxt = 16'h0000;
                tgt_nxt = 16'h0000;
            end
            `CMD_DUAL:
            begin
                dwait_nxt = 1'b1;
                t1_nxt = ex_a;
                off_nxt = arg_r[31:16];
                svmin_nxt = vel_r[3:0];
                svmax_nxt = vel_r[7:4];
            end
            `CMD_SOFT: soft_nxt = 1'b1;
            `CMD_DRIVE: ram_nxt = vel_r;
            default: ex_v = 1'b0;
        endcase
    end
    if (cmd_go & cmd_code == `CMD_HARD)
    begin
        go = 1'b0;
        hard_nxt = 1'b1;
        state_nxt = st_idle;
        dwait_nxt = 1'b0;
    end
    start_nxt = go;
    mtgt_nxt = go ? go_tgt : mtgt_r;
    mvmin_nxt = go ? go_vmin : mvmin_r;
    mvmax_nxt = go ? go_vmax : mvmax_r;
    ramp_nxt = go ? go_ramp : ramp_r;
    // Next location, so a move launched while zeroing sees zero
    dir_nxt = go ? way_up(go_tgt, act_nxt) : dir_r;
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_r <= st_idle;
        resume_r <= st_idle;
        {act_r, tgt_r, t1_r, off_r, bufa_r, mtgt_r} <= 96'h0;
        {svmin_r, svmax_r, bufc_r, mvmin_r, mvmax_r} <= 20'h0;
        ram_r <= `RAM_VEL_RST;
        bufv11_r <= `VEL_RST;
        {uv2_r, sl_r, ref_r, dwait_r, bufv_r} <= 5'h00;
        {start_r, ramp_r, dir_r, hard_r, soft_r, slp_r} <= 6'h00;
    end
    else
    begin
        state_r <= state_nxt;
        resume_r <= resume_nxt;
        {act_r, tgt_r, t1_r, off_r, bufa_r, mtgt_r} <=
            {act_nxt, tgt_nxt, t1_nxt, off_nxt, bufa_nxt, mtgt_nxt};
        {svmin_r, svmax_r, bufc_r, mvmin_r, mvmax_r} <=
            {svmin_nxt, svmax_nxt, bufc_nxt, mvmin_nxt, mvmax_nxt};
        ram_r <= ram_nxt;
        bufv11_r <= bufv11_nxt;
        {uv2_r, sl_r, ref_r, dwait_r, bufv_r} <=
            {uv2_nxt, sl_nxt, ref_nxt, dwait_nxt, bufv_nxt};
        {start_r, ramp_r, dir_r, hard_r, soft_r, slp_r} <=
            {start_nxt, ramp_nxt, dir_nxt, hard_nxt, soft_nxt, slp_nxt};
    end
end

assign {prdata, pready, pslverr} = {prdata_r, pready_r, pslverr_r};
assign {mv_start, mv_target, mv_vmin, mv_vmax} =
    {start_r, mtgt_r, mvmin_r, mvmax_r};
assign {mv_accel, mv_ramp, mv_dir} = {ram_r[10:8], ramp_r, dir_r};
assign {mv_hard_stop, mv_soft_stop, sleep_req, referenced} =
    {hard_r, soft_r, slp_r, ref_r};

////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
logic hard_cmd;
assign hard_cmd = cmd_go & cmd_code == `CMD_HARD;
sequence p1_done_s;
    state_r == st_phase1 && mv_done && !uv_mid && !uv_upper && !hard_cmd;
endsequence
first_move_a: assert property (state_r == st_idle && dwait_r
    && !uv2_r && !sl_r && !hard_cmd |=> mv_start && mv_ramp
    && mv_target == t1_r && mv_vmin == svmin_r && state_r == st_phase1)
    else $error("first move not started with command speeds");
second_move_a: assert property (p1_done_s |=> mv_start
    && !mv_ramp && mv_target == add16(t1_r, off_r)
    && mv_vmin == svmin_r && mv_vmax == svmin_r)
    else $error("second move wrong");
// A move, parameter or park command drained at the same edge sets its own target
end_zero_a: assert property (seq_end && !uv_mid && !uv_upper
    && !hard_cmd && (park_en || !bufv_r) |=> act_r == 16'h0000
    && referenced && tgt_r == (park_en ? park16 : 16'h0000))
    else $error("sequence end did not zero location");
park_go_a: assert property (seq_end && park_en && !uv_mid
    && !uv_upper && !hard_cmd |=> mv_start && mv_target == park16)
    else $error("park move missing after sequence");
hard_stop_a: assert property (hard_cmd |=> mv_hard_stop
    && state_r == st_idle && !mv_start)
    else $error("hard stop not honoured");
hold_cmd_a: assert property (in_seq && state_r != st_uv_hold
    && cmd_go && cmd_code == `CMD_ABS && !hard_cmd && !mv_done
    |=> bufv_r && bufa_r == $past(arg_r[15:0]))
    else $error("move not buffered during sequence");
drop_cmd_a: assert property (in_seq && state_r != st_uv_hold
    && cmd_go && cmd_code == `CMD_ZERO && !mv_done && !uv_mid
    && !uv_upper |=> tgt_r == $past(tgt_r)
    && (act_r == $past(act_r) || $past(step_pulse)))
    else $error("zero command executed during sequence");
uv_mid_a: assert property (in_seq && state_r != st_uv_hold
    && uv_mid && !hard_cmd |=> mv_hard_stop && state_r == st_uv_hold)
    else $error("middle level did not hard stop");
resume_a: assert property (state_r == st_uv_hold && uv_recovered
    && !hard_cmd |=> mv_start && mv_vmin == ram_r[3:0]
    && mv_vmax == ram_r[7:4])
    else $error("resume not on RAM speeds");
flag_gate_a: assert property (state_r == st_idle && dwait_r
    && (uv2_r || sl_r) |=> state_r != st_phase1)
    else $error("sequence started with flags set");

endmodule : dual_position_sequencer

/* File: dual_pos_defs.svh */
// Register offsets, command codes and reset values of the sequencer
`ifndef DUAL_POS_DEFS_SVH
`define DUAL_POS_DEFS_SVH
`define OFF_CMD 8'h00
`define OFF_ARG 8'h04
`define OFF_VEL 8'h08
`define OFF_PARK 8'h0C
`define OFF_STAT 8'h10
`define OFF_POS 8'h14
`define OFF_RAM 8'h18
`define CMD_ABS 4'h1
`define CMD_PARAM 4'h2
`define CMD_PARK 4'h3
`define CMD_SLEEP 4'h4
`define CMD_ZERO 4'h5
`define CMD_DUAL 4'h6
`define CMD_SOFT 4'h7
`define CMD_HARD 4'h8
`define CMD_DRIVE 4'h9
`define CMD_RD_LOC 4'hA
`define CMD_RD_ALL 4'hB
`define PARK_OFF 11'h400
`define PARK_RST 11'h400
`define VEL_RST 11'h000
`define RAM_VEL_RST 11'h000
`endif

/* File: dual_pos_pkg.sv */
// Types shared by the sequencer
package dual_pos_pkg;
    typedef enum logic [2:0] {st_idle, st_phase1, st_phase2, st_park,
        st_uv_hold} seq_state_t;
endpackage : dual_pos_pkg

/* File: motion_engine_model.sv */
// Behavioural motion engine on the far side of the sequencer
`timescale 1ns/1ns
module motion_engine_model #(
    parameter int DLY = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mv_start,
    input wire logic mv_dir,
    input wire logic [15:0] mv_target,
    input wire logic mv_hard_stop,
    output logic mv_done,
    output logic step_pulse,
    output logic step_down
);
    int cnt;
    // Latency follows the target so answers come both sooner and later
    // One step just before arrival keeps location stable during a move
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cnt <= 0;
            mv_done <= 1'b0;
            step_pulse <= 1'b0;
            step_down <= 1'b0;
        end
        else
        begin
            mv_done <= 1'b0;
            step_pulse <= 1'b0;
            if (mv_start)
            begin
                cnt <= DLY + mv_target[3:0];
                step_down <= ~mv_dir;
            end
            else if (mv_hard_stop)
                cnt <= 0;
            else if (cnt > 0)
            begin
                cnt <= cnt - 1;
                step_pulse <= (cnt == 2);
                mv_done <= (cnt == 1);
            end
        end
endmodule : motion_engine_model

/* File: test_dual_position_sequencer.sv */
// Self-checking bench for the referencing sequencer
`timescale 1ns/1ns
`include "dual_pos_defs.svh"
module test_dual_position_sequencer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic mv_done, step_pulse, step_down, uv_mid, uv_recovered;
    logic uv_upper, steploss_in;
    logic mv_start, mv_ramp, mv_dir, mv_hard_stop, mv_soft_stop;
    logic sleep_req, referenced;
    logic [15:0] mv_target;
    logic [3:0] mv_vmin, mv_vmax;
    logic [2:0] mv_accel;
    logic [28:0] starts[$];
    int errors, n_checks, hard_n, soft_n, slp_n;

    dual_position_sequencer u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mv_done(mv_done), .step_pulse(step_pulse),
        .step_down(step_down), .uv_mid(uv_mid), .uv_upper(uv_upper),
        .uv_recovered(uv_recovered), .steploss_in(steploss_in),
        .mv_start(mv_start), .mv_target(mv_target), .mv_vmin(mv_vmin),
        .mv_vmax(mv_vmax), .mv_accel(mv_accel), .mv_ramp(mv_ramp),
        .mv_dir(mv_dir), .mv_hard_stop(mv_hard_stop),
        .mv_soft_stop(mv_soft_stop), .sleep_req(sleep_req),
        .referenced(referenced));
    motion_engine_model u_eng (.pclk(pclk), .presetn(presetn),
        .mv_start(mv_start), .mv_dir(mv_dir), .mv_target(mv_target),
        .mv_hard_stop(mv_hard_stop), .mv_done(mv_done),
        .step_pulse(step_pulse), .step_down(step_down));

    always #10 pclk = ~pclk;
    // Pulses are one cycle wide, so every edge is watched
    always @(posedge pclk)
    begin
        if (mv_start === 1'b1)
            starts.push_back({mv_target, mv_vmin, mv_vmax, mv_accel,
                mv_ramp, mv_dir});
        if (mv_hard_stop === 1'b1)
            hard_n++;
        if (mv_soft_stop === 1'b1)
            soft_n++;
        if (sleep_req === 1'b1)
            slp_n++;
    end
    ////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, a, 32'h0);
        chk("read", e, rdata & m);
    endtask : rd
    // Next move request; dc set means the direction is compared too
    task go(input logic [28:0] e, input logic dc);
        int i;
        logic [28:0] g;
        i = 0;
        while (starts.size() == 0 && i < 200)
        begin
            @(posedge pclk);
            i++;
        end
        g = (starts.size() > 0) ? starts.pop_front() : 29'h0;
        if (!dc)
            g[0] = e[0];
        chk("move", {3'h0, e}, {3'h0, g});
    endtask : go
    task wait_done;
        int i;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end while (mv_done !== 1'b1 && i < 200);
        chk("move done", 32'h1, {31'h0, mv_done});
    endtask : wait_done
    task close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        close_out;
    end
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, uv_mid, uv_upper,
            steploss_in} = 8'h00;
        uv_recovered = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFF_STAT, 32'h0, 32'hFFFFFFFF);
        rd(`OFF_PARK, 32'h400, 32'h7FF);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        chk("slverr", 32'h1, {31'h0, rerr});
        wr(`OFF_VEL, 32'h512);
        wr(`OFF_CMD, `CMD_DRIVE);
        // Plain run with a buffered move and discarded commands
        wr(`OFF_VEL, 32'h3A4);
        wr(`OFF_ARG, 32'h0020_7FF0);
        wr(`OFF_CMD, `CMD_DUAL);
        go({16'h7FF0, 4'h4, 4'hA, 3'h5, 2'b10}, 0);
        rd(`OFF_POS, 32'h0, 32'hFFFF0000);
        wr(`OFF_ARG, 32'h1234);
        wr(`OFF_CMD, `CMD_ABS);
        wr(`OFF_CMD, `CMD_ZERO);
        wr(`OFF_CMD, `CMD_SOFT);
        wr(`OFF_CMD, `CMD_DUAL);
        wr(`OFF_CMD, `CMD_RD_LOC);
        rd(`OFF_STAT, 32'h81, 32'h87);
        wr(`OFF_VEL, 32'h677);
        wr(`OFF_CMD, `CMD_DRIVE);
        wait_done;
        go({16'h8010, 4'h4, 4'h4, 3'h6, 2'b00}, 0);
        wait_done;
        go({16'h1234, 4'h2, 4'h1, 3'h6, 2'b11}, 1);
        rd(`OFF_POS, 32'h0, 32'hFFFF);
        chk("referenced", 32'h1, {31'h0, referenced});
        chk("soft stops", 32'h0, soft_n);
        wait_done;
        chk("extra moves", 32'h0, starts.size());
        wr(`OFF_ARG, 32'h9000);
        wr(`OFF_CMD, `CMD_ABS);
        go({16'h9000, 4'h2, 4'h1, 3'h6, 2'b10}, 1);
        wait_done;
        // Park enabled, wrapping second destination
        wr(`OFF_PARK, 32'h010);
        wr(`OFF_VEL, 32'h0A3);
        wr(`OFF_ARG, 32'hFFFF_0005);
        wr(`OFF_CMD, `CMD_DUAL);
        go({16'h0005, 4'h3, 4'hA, 3'h6, 2'b10}, 0);
        rd(`OFF_POS, 32'h0200_0000, 32'hFFFF0000);
        wr(`OFF_CMD, `CMD_ZERO);
        rd(`OFF_POS, 32'h0200_0000, 32'hFFFF0000);
        wait_done;
        go({16'h0004, 4'h3, 4'h3, 3'h6, 2'b00}, 0);
        wait_done;
        go({16'h0200, 4'h2, 4'h1, 3'h6, 2'b10}, 0);
        rd(`OFF_POS, 32'h0200_0000, 32'hFFFFFFFF);
        wait_done;
        // Hard stop aborts the sequence
        wr(`OFF_CMD, `CMD_DUAL);
        go({16'h0005, 4'h3, 4'hA, 3'h6, 2'b10}, 0);
        wr(`OFF_CMD, `CMD_HARD);
        rd(`OFF_STAT, 32'h0, 32'h7);
        chk("hard stops", 32'h1, hard_n);
        // Supply dip in phase one, then recovery
        wr(`OFF_CMD, `CMD_DUAL);
        go({16'h0005, 4'h3, 4'hA, 3'h6, 2'b10}, 0);
        uv_mid <= 1'b1;
        uv_recovered <= 1'b0;
        @(posedge pclk);
        uv_mid <= 1'b0;
        rd(`OFF_STAT, 32'h4, 32'h7);
        chk("hard stops", 32'h2, hard_n);
        uv_recovered <= 1'b1;
        go({16'h0005, 4'h2, 4'h1, 3'h6, 2'b10}, 0);
        wait_done;
        go({16'h0004, 4'h3, 4'h3, 3'h6, 2'b00}, 0);
        wait_done;
        go({16'h0200, 4'h2, 4'h1, 3'h6, 2'b10}, 0);
        wait_done;
        // Flags left set hold back the next sequence
        steploss_in <= 1'b1;
        @(posedge pclk);
        steploss_in <= 1'b0;
        wr(`OFF_CMD, `CMD_DUAL);
        rd(`OFF_STAT, 32'h70, 32'h70);
        chk("early move", 32'h0, starts.size());
        wr(`OFF_CMD, `CMD_RD_ALL);
        go({16'h0005, 4'h3, 4'hA, 3'h6, 2'b10}, 0);
        // Upper level dip: soft stop, then held until a hard stop ends it
        uv_upper <= 1'b1;
        uv_recovered <= 1'b0;
        @(posedge pclk);
        uv_upper <= 1'b0;
        rd(`OFF_STAT, 32'h4, 32'h7);
        chk("soft stops", 32'h1, soft_n);
        wr(`OFF_CMD, `CMD_HARD);
        wr(`OFF_CMD, `CMD_SLEEP);
        go({16'h0200, 4'h2, 4'h1, 3'h6, 2'b10}, 0);
        chk("sleep", 32'h1, slp_n);
        wr(`OFF_ARG, 32'h0007);
        wr(`OFF_CMD, `CMD_PARAM);
        go({16'h0007, 4'h3, 4'hA, 3'h6, 2'b10}, 0);
        repeat (3) @(posedge pclk);
        close_out;
    end
endmodule : test_dual_position_sequencer
